/* rtl/irq_merge.v */
// Merges the port interrupt sources into one single-cycle low pulse.
`timescale 1ns/1ps
module irq_merge (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Qualified level sources and event pulses
  input wire [3:0] src_level_in,
  input wire [2:0] src_pulse_in,
  input wire hold_in,
  // Request
  output reg irq_n_out,
  output reg irq_evt_out
);

  reg [3:0] level_prev;
  reg pending;
  wire rise;

  assign rise = |(src_level_in & ~level_prev) | (|src_pulse_in);

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      level_prev <= 4'h0;
      pending <= 1'b0;
      irq_n_out <= 1'b1;
      irq_evt_out <= 1'b0;
    end else begin
      level_prev <= src_level_in;
      irq_n_out <= 1'b1;
      irq_evt_out <= 1'b0;
      if (hold_in) begin
        pending <= pending | rise;
      end else if (rise || pending) begin
        pending <= 1'b0;
        irq_n_out <= 1'b0;
        irq_evt_out <= 1'b1;
      end
    end
  end

endmodule

/* rtl/uart_irq_defs.vh */
// Constants for the serial port interrupt, address-detect and wake block.
`ifndef UART_IRQ_DEFS_VH
`define UART_IRQ_DEFS_VH

`define ADDR_STATUS 2'h0
`define ADDR_CTRL_ONE 2'h1
`define ADDR_CTRL_TWO 2'h2
`define ADDR_DATA 2'h3

`define ST_PARITY 0
`define ST_FRAMING 1
`define ST_OVERRUN 2
`define ST_RX_AVAIL 3
`define ST_TX_EMPTY 4
`define ST_TX_IDLE 5
`define ST_RX_IDLE 6

`define C1_PORT_EN 0
`define C1_NINE_BIT 1
`define C1_PARITY_EN 2
`define C1_PARITY_ODD 3
`define C1_PARITY_TYPE 4
`define C1_RX_TOP 5

`define C2_ADDR_MODE 0
`define C2_RX_IRQ_EN 1
`define C2_TXE_IRQ_EN 2
`define C2_TXI_IRQ_EN 3
`define C2_WAKE_EN 4
`define C2_RX_ON 5
`define C2_PORT_IRQ_EN 6

`define CTRL_ONE_RESET 8'h00
`define CTRL_TWO_RESET 8'h00

`define CLK_PERIOD_NS 25
`define START_TIME_NS 100000
`define START_CYCLES ((`START_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/uart_irq_wake.v */
// Serial port interrupt, address-detect and power-down wake logic.
`timescale 1ns/1ps
`include "uart_irq_defs.vh"
module uart_irq_wake (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Register port
  input wire [1:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rd_data_out,
  // Receiver core
  input wire rx_word_valid_in,
  input wire [8:0] rx_word_in,
  input wire rx_parity_bit_in,
  input wire rx_framing_bad_in,
  input wire rx_busy_in,
  // Transmitter core
  input wire tx_empty_in,
  input wire tx_idle_in,
  input wire tx_busy_in,
  output reg [7:0] tx_data_out,
  output reg tx_load_out,
  // Receive pin
  input wire rx_pin_in,
  // Power and interrupt controller
  input wire clk_off_in,
  input wire global_irq_enable_in,
  input wire stack_full_in,
  output reg irq_n_out,
  output reg vector_req_out,
  output reg wake_out,
  output reg rx_ignore_out,
  output reg tx_pause_out,
  output reg rx_pause_out
);

  reg [7:0] serial_ctrl_reg_one;
  reg [7:0] serial_ctrl_reg_two;
  reg [7:0] serial_data_buffer;
  reg parity_fault_flag;
  reg framing_fault_flag;
  reg overrun_flag;
  reg rx_data_avail_flag;
  reg rx_top_bit;
  reg status_seen;
  reg rx_pin_prev;
  reg wake_pending;
  reg addr_pulse;
  reg wake_pulse;
  reg next_parity_fault;
  reg next_framing_fault;
  reg next_overrun;
  reg next_rx_avail;
  reg [7:0] read_mux;

  wire serial_port_enable;
  wire nine_bit_word_select;
  wire parity_check_enable;
  wire parity_odd_select;
  wire parity_type_valid;
  wire addr_match_mode_enable;
  wire receive_irq_enable;
  wire tx_empty_irq_enable;
  wire tx_idle_irq_enable;
  wire rx_edge_resume_enable;
  wire receiver_on;
  wire serial_port_irq_enable;
  wire startup_busy;
  wire startup_done;
  wire merge_n;
  wire merge_evt;
  wire word_take;
  wire word_parity_bad;
  wire data_read;
  wire data_clear;
  wire rx_fall;
  wire [3:0] level_src;
  wire [2:0] pulse_src;

  function top_bit;
    input [8:0] word;
    input nine;
    begin
      top_bit = nine ? word[8] : word[7];
    end
  endfunction

  assign serial_port_enable = serial_ctrl_reg_one[`C1_PORT_EN];
  assign nine_bit_word_select = serial_ctrl_reg_one[`C1_NINE_BIT];
  assign parity_check_enable = serial_ctrl_reg_one[`C1_PARITY_EN];
  assign parity_odd_select = serial_ctrl_reg_one[`C1_PARITY_ODD];
  assign parity_type_valid = serial_ctrl_reg_one[`C1_PARITY_TYPE];
  assign addr_match_mode_enable = serial_ctrl_reg_two[`C2_ADDR_MODE];
  assign receive_irq_enable = serial_ctrl_reg_two[`C2_RX_IRQ_EN];
  assign tx_empty_irq_enable = serial_ctrl_reg_two[`C2_TXE_IRQ_EN];
  assign tx_idle_irq_enable = serial_ctrl_reg_two[`C2_TXI_IRQ_EN];
  assign rx_edge_resume_enable = serial_ctrl_reg_two[`C2_WAKE_EN];
  assign receiver_on = serial_ctrl_reg_two[`C2_RX_ON];
  assign serial_port_irq_enable = serial_ctrl_reg_two[`C2_PORT_IRQ_EN];

  // A word is taken only with the clock running and start-up over.
  assign word_take = rx_word_valid_in && !clk_off_in && !startup_busy;

  // Parity over the active data bits and the parity bit.
  assign word_parity_bad = (^{nine_bit_word_select & rx_word_in[8],
    rx_word_in[7:0], rx_parity_bit_in}) ^ parity_odd_select;

  assign data_read = rd_in && addr_in == `ADDR_DATA;
  assign data_clear = data_read && status_seen;
  assign rx_fall = rx_pin_prev && !rx_pin_in;

  // Level sources, each masked by its enable; data-available and overrun share the receive enable.
  assign level_src[0] = tx_empty_in && tx_empty_irq_enable;
  assign level_src[1] = tx_idle_in && tx_idle_irq_enable;
  assign level_src[2] = rx_data_avail_flag && receive_irq_enable &&
    (!addr_match_mode_enable || rx_top_bit);
  assign level_src[3] = overrun_flag && receive_irq_enable;
  assign pulse_src[0] = addr_pulse;
  assign pulse_src[1] = wake_pulse;
  assign pulse_src[2] = 1'b0;

  wake_timer u_wake_timer (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .clk_off_in(clk_off_in),
    .busy_out(startup_busy),
    .done_out(startup_done)
  );

  irq_merge u_irq_merge (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .src_level_in(level_src),
    .src_pulse_in(pulse_src),
    .hold_in(startup_busy),
    .irq_n_out(merge_n),
    .irq_evt_out(merge_evt)
  );

  // Next values of the status flags; a set wins over a clear.
  always @* begin
    next_parity_fault = parity_fault_flag;
    next_framing_fault = framing_fault_flag;
    next_overrun = overrun_flag;
    next_rx_avail = rx_data_avail_flag;
    if (data_clear) begin
      next_parity_fault = 1'b0;
      next_framing_fault = 1'b0;
      next_overrun = 1'b0;
      next_rx_avail = 1'b0;
    end
    if (word_take) begin
      if (rx_data_avail_flag && !data_clear) begin
        next_overrun = 1'b1;
      end else begin
        next_rx_avail = 1'b1;
        next_parity_fault = parity_check_enable && parity_type_valid &&
          word_parity_bad;
        next_framing_fault = rx_framing_bad_in;
      end
    end
  end

  // Status flags and the received word.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      parity_fault_flag <= 1'b0;
      framing_fault_flag <= 1'b0;
      overrun_flag <= 1'b0;
      rx_data_avail_flag <= 1'b0;
      serial_data_buffer <= 8'h00;
      rx_top_bit <= 1'b0;
      addr_pulse <= 1'b0;
    end else begin
      parity_fault_flag <= next_parity_fault;
      framing_fault_flag <= next_framing_fault;
      overrun_flag <= next_overrun;
      rx_data_avail_flag <= next_rx_avail;
      addr_pulse <= 1'b0;
      if (word_take && (!rx_data_avail_flag || data_clear)) begin
        serial_data_buffer <= rx_word_in[7:0];
        rx_top_bit <= top_bit(rx_word_in, nine_bit_word_select);
        addr_pulse <= addr_match_mode_enable &&
          top_bit(rx_word_in, nine_bit_word_select);
      end
    end
  end

  // Control registers; writes are refused while the port clock is off.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      serial_ctrl_reg_one <= `CTRL_ONE_RESET;
      serial_ctrl_reg_two <= `CTRL_TWO_RESET;
    end else if (wr_in && !clk_off_in) begin
      if (addr_in == `ADDR_CTRL_ONE) begin
        serial_ctrl_reg_one <= {3'h0, wr_data_in[4:0]};
      end
      if (addr_in == `ADDR_CTRL_TWO) begin
        serial_ctrl_reg_two <= {1'b0, wr_data_in[6:0]};
      end
    end
  end

  // Status-then-data access sequence tracking and transmit load.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      status_seen <= 1'b0;
      tx_data_out <= 8'h00;
      tx_load_out <= 1'b0;
    end else begin
      tx_load_out <= 1'b0;
      if (rd_in && addr_in == `ADDR_STATUS) begin
        status_seen <= 1'b1;
      end else if (data_read) begin
        status_seen <= 1'b0;
      end
      if (wr_in && addr_in == `ADDR_DATA && !clk_off_in) begin
        tx_data_out <= wr_data_in;
        tx_load_out <= 1'b1;
      end
    end
  end

  // Read multiplexer; status flags have no write path.
  always @* begin
    read_mux = 8'h00;
    case (addr_in)
      `ADDR_STATUS: begin
        read_mux[`ST_PARITY] = parity_fault_flag;
        read_mux[`ST_FRAMING] = framing_fault_flag;
        read_mux[`ST_OVERRUN] = overrun_flag;
        read_mux[`ST_RX_AVAIL] = rx_data_avail_flag;
        read_mux[`ST_TX_EMPTY] = tx_empty_in;
        read_mux[`ST_TX_IDLE] = tx_idle_in;
        read_mux[`ST_RX_IDLE] = !rx_busy_in;
      end
      `ADDR_CTRL_ONE: begin
        read_mux = serial_ctrl_reg_one;
        read_mux[`C1_RX_TOP] = rx_top_bit;
      end
      `ADDR_CTRL_TWO: begin
        read_mux = serial_ctrl_reg_two;
      end
      `ADDR_DATA: begin
        read_mux = serial_data_buffer;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_in) begin
      rd_data_out <= read_mux;
    end else begin
      rd_data_out <= 8'h00;
    end
  end

  // Receive-pin wake while the port clock is off.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rx_pin_prev <= 1'b1;
      wake_out <= 1'b0;
      wake_pending <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      rx_pin_prev <= rx_pin_in;
      wake_out <= 1'b0;
      wake_pulse <= 1'b0;
      if (clk_off_in && rx_fall && rx_edge_resume_enable &&
          serial_port_enable && receiver_on && receive_irq_enable) begin
        wake_out <= 1'b1;
        if (global_irq_enable_in && serial_port_irq_enable) begin
          wake_pending <= 1'b1;
        end
      end else if (startup_done && wake_pending) begin
        wake_pending <= 1'b0;
        wake_pulse <= 1'b1;
      end
    end
  end

  // Outputs toward the interrupt controller and the shift cores.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_n_out <= 1'b1;
      vector_req_out <= 1'b0;
      rx_ignore_out <= 1'b0;
      tx_pause_out <= 1'b0;
      rx_pause_out <= 1'b0;
    end else begin
      irq_n_out <= merge_n;
      vector_req_out <= merge_evt && global_irq_enable_in &&
        serial_port_irq_enable && !stack_full_in;
      rx_ignore_out <= startup_busy;
      tx_pause_out <= clk_off_in && tx_busy_in;
      rx_pause_out <= clk_off_in && rx_busy_in;
    end
  end

endmodule

/* rtl/wake_timer.v */
// Times the start-up interval after the port clock returns.
`timescale 1ns/1ps
`include "uart_irq_defs.vh"
module wake_timer (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Port clock state
  input wire clk_off_in,
  // Start-up status
  output reg busy_out,
  output reg done_out
);

  localparam [31:0] LAST_FULL = `START_CYCLES - 1;
  localparam [11:0] LAST = LAST_FULL[11:0];
  reg [11:0] count;

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      count <= 12'h000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (clk_off_in) begin
        count <= 12'h000;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (count == LAST) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count + 12'h001;
        end
      end
    end
  end

endmodule

/* sim/rx_remote_model.sv */
// Remote serial device: finished words and the receive pin level.
`timescale 1ns/1ps
module rx_remote_model (
  // Clock
  input wire clk_sys_in,
  // Finished words
  output logic valid_out = 1'h0,
  output logic [8:0] word_out = 9'h000,
  output logic parity_out = 1'h0,
  output logic frame_bad_out = 1'h0,
  // Receive pin, idles high
  output logic pin_out = 1'h1
);
  task automatic send(input logic [8:0] w, input logic p, input logic f);
    @(posedge clk_sys_in);
    valid_out <= 1'h1;
    word_out <= w;
    parity_out <= p;
    frame_bad_out <= f;
    @(posedge clk_sys_in);
    valid_out <= 1'h0;
    word_out <= ~w;
    parity_out <= ~p;
    frame_bad_out <= ~f;
  endtask
  task automatic fall();
    @(posedge clk_sys_in);
    pin_out <= 1'h0;
    repeat (4) @(posedge clk_sys_in);
    pin_out <= 1'h1;
  endtask
endmodule

/* sim/test_uart_irq_wake.sv */
// Self-checking bench for the serial interrupt and wake block.
`timescale 1ns/1ps
module test_uart_irq_wake;
  logic clk_sys_in, rst_in, wr_in, rd_in, tx_empty_in, tx_idle_in;
  logic tx_busy_in, rx_busy_in, clk_off_in, global_irq_enable_in;
  logic stack_full_in, rx_word_valid_in, rx_parity_bit_in;
  logic rx_framing_bad_in, rx_pin_in, irq_n_out, vector_req_out;
  logic wake_out, rx_ignore_out, tx_pause_out, rx_pause_out, tx_load_out;
  logic [1:0] addr_in;
  logic [7:0] wr_data_in, rd_data_out, rv, tx_data_out;
  logic [8:0] rx_word_in;
  logic [27:0] rows [0:10];
  logic [27:0] r;
  integer num_errors = 0, samples_checked = 0, i, early;
  uart_irq_wake u_uart_irq_wake (.clk_sys_in, .rst_in, .addr_in,
    .wr_data_in, .wr_in, .rd_in, .rd_data_out, .rx_word_valid_in,
    .rx_word_in, .rx_parity_bit_in, .rx_framing_bad_in, .rx_busy_in,
    .tx_empty_in, .tx_idle_in, .tx_busy_in, .tx_data_out, .tx_load_out,
    .rx_pin_in, .clk_off_in, .global_irq_enable_in, .stack_full_in,
    .irq_n_out, .vector_req_out, .wake_out, .rx_ignore_out, .tx_pause_out,
    .rx_pause_out);
  rx_remote_model u_rx_remote_model (.clk_sys_in,
    .valid_out(rx_word_valid_in), .word_out(rx_word_in),
    .parity_out(rx_parity_bit_in), .frame_bad_out(rx_framing_bad_in),
    .pin_out(rx_pin_in));
  initial begin
    clk_sys_in = 1'h0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'h1;
    @(posedge clk_sys_in);
    wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge clk_sys_in);
    rd_in <= 1'h0;
    #1 rv = rd_data_out;
  endtask
  // Looks for a request, a vector and a wake pulse over eight cycles.
  task automatic watch(input logic ei, input logic ev, input logic ew);
    int ni = 0, nv = 0, nw = 0;
    repeat (8) begin
      @(posedge clk_sys_in);
      #1;
      if (irq_n_out === 1'h0) ni++;
      if (vector_req_out === 1'h1) nv++;
      if (wake_out === 1'h1) nw++;
    end
    chk(ni > 0, ei);
    chk(nv > 0, ev);
    chk(nw > 0, ew);
  endtask
  task automatic settle();
    early = 0;
    for (i = 0; i < 4200 && rx_ignore_out !== 1'h0; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (irq_n_out === 1'h0) early++;
    end
  endtask
  task automatic wrap_up();
    $display("Checks: %0d, errors: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    wrap_up();
  end
  initial begin
    rows[0] = {8'h01, 8'h42, 9'h000, 3'h2};
    rows[1] = {8'h01, 8'h42, 9'h080, 3'h2};
    rows[2] = {8'h01, 8'h43, 9'h000, 3'h0};
    rows[3] = {8'h01, 8'h43, 9'h080, 3'h2};
    rows[4] = {8'h03, 8'h43, 9'h080, 3'h0};
    rows[5] = {8'h03, 8'h43, 9'h100, 3'h2};
    rows[6] = {8'h01, 8'h40, 9'h080, 3'h0};
    rows[7] = {8'h15, 8'h42, 9'h001, 3'h3};
    rows[8] = {8'h15, 8'h42, 9'h001, 3'h6};
    rows[9] = {8'h05, 8'h42, 9'h001, 3'h2};
    rows[10] = {8'h1D, 8'h42, 9'h001, 3'h2};
    rst_in = 1'h1;
    wr_in = 1'h0;
    rd_in = 1'h0;
    addr_in = 2'h0;
    wr_data_in = 8'h00;
    tx_empty_in = 1'h0;
    tx_idle_in = 1'h0;
    tx_busy_in = 1'h0;
    rx_busy_in = 1'h0;
    clk_off_in = 1'h0;
    global_irq_enable_in = 1'h1;
    stack_full_in = 1'h0;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    #1 chk(irq_n_out, 1'h1);
    wr(2'h0, 8'hFF);
    rd(2'h0);
    chk(rv & 8'h0F, 8'h00);
    for (i = 0; i < 11; i++) begin
      r = rows[i];
      wr(2'h1, r[27:20]);
      wr(2'h2, r[19:12]);
      u_rx_remote_model.send(r[11:3], r[2], 1'h0);
      watch(r[1], r[1], 1'h0);
      rd(2'h1);
      chk(rv, {r[27:26], r[21] ? r[11] : r[10], r[24:20]});
      rd(2'h0);
      chk(rv & 8'h09, {4'h0, 1'h1, 2'h0, r[0]});
      rd(2'h3);
      chk(rv, r[10:3]);
      rd(2'h0);
      chk(rv & 8'h0F, 8'h00);
    end
    wr(2'h1, 8'h01);
    u_rx_remote_model.send(9'h055, 1'h0, 1'h1);
    watch(1'h1, 1'h1, 1'h0);
    u_rx_remote_model.send(9'h0AA, 1'h0, 1'h0);
    watch(1'h1, 1'h1, 1'h0);
    rd(2'h0);
    chk(rv & 8'h0F, 8'h0E);
    rd(2'h3);
    chk(rv, 8'h55);
    stack_full_in <= 1'h1;
    wr(2'h2, 8'h44);
    tx_empty_in <= 1'h1;
    watch(1'h1, 1'h0, 1'h0);
    stack_full_in <= 1'h0;
    tx_empty_in <= 1'h0;
    wr(2'h2, 8'h48);
    tx_empty_in <= 1'h1;
    watch(1'h0, 1'h0, 1'h0);
    tx_idle_in <= 1'h1;
    watch(1'h1, 1'h1, 1'h0);
    tx_empty_in <= 1'h0;
    tx_idle_in <= 1'h0;
    wr(2'h3, 8'h3C);
    #1 chk({tx_load_out, tx_data_out}, 9'h13C);
    wr(2'h2, 8'h72);
    clk_off_in <= 1'h1;
    tx_busy_in <= 1'h1;
    rx_busy_in <= 1'h1;
    wr(2'h2, 8'h00);
    wr(2'h3, 8'hA5);
    #1 chk({tx_load_out, tx_data_out}, 9'h03C);
    chk({tx_pause_out, rx_pause_out}, 9'h003);
    fork
      u_rx_remote_model.fall();
      watch(1'h0, 1'h0, 1'h1);
    join
    clk_off_in <= 1'h0;
    tx_busy_in <= 1'h0;
    rx_busy_in <= 1'h0;
    u_rx_remote_model.send(9'h0C3, 1'h0, 1'h0);
    #1 chk(rx_ignore_out, 1'h1);
    settle();
    chk(9'(early), 9'h000);
    chk({tx_pause_out, rx_pause_out}, 9'h000);
    watch(1'h1, 1'h1, 1'h0);
    rd(2'h2);
    chk(rv, 8'h72);
    rd(2'h0);
    chk(rv & 8'h08, 8'h00);
    global_irq_enable_in <= 1'h0;
    clk_off_in <= 1'h1;
    fork
      u_rx_remote_model.fall();
      watch(1'h0, 1'h0, 1'h1);
    join
    clk_off_in <= 1'h0;
    settle();
    watch(1'h0, 1'h0, 1'h0);
    wr(2'h1, 8'h15);
    u_rx_remote_model.send(9'h001, 1'h0, 1'h0);
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    rd(2'h0);
    chk(rv & 8'h0F, 8'h00);
    wrap_up();
  end
endmodule

/* sim/uart_irq_wake_properties.sv */
// Concurrent checks on the ports of the serial interrupt and wake block.
`timescale 1ns/1ps
module uart_irq_wake_properties (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Observed inputs
  input wire [1:0] addr_in,
  input wire wr_in,
  input wire rx_word_valid_in,
  input wire rx_busy_in,
  input wire tx_busy_in,
  input wire rx_pin_in,
  input wire clk_off_in,
  input wire global_irq_enable_in,
  input wire stack_full_in,
  // Observed outputs
  input wire tx_load_out,
  input wire irq_n_out,
  input wire vector_req_out,
  input wire wake_out,
  input wire rx_ignore_out,
  input wire tx_pause_out,
  input wire rx_pause_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  property p_irq_pulse;
    !irq_n_out |=> irq_n_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("request held low too long");
  property p_vec_gate;
    vector_req_out == (!irq_n_out && $past(global_irq_enable_in) &&
      !$past(stack_full_in));
  endproperty
  a_vec_gate: assert property (p_vec_gate)
    else $error("vector request not gated");
  property p_wake_edge;
    wake_out |-> $past(clk_off_in) && !$past(rx_pin_in) && $past(rx_pin_in, 2);
  endproperty
  a_wake_edge: assert property (p_wake_edge)
    else $error("wake without falling edge");
  property p_ignore_irq;
    rx_ignore_out |-> irq_n_out;
  endproperty
  a_ignore_irq: assert property (p_ignore_irq)
    else $error("request during start-up");
  property p_ignore_word;
    rx_word_valid_in && rx_ignore_out |=> irq_n_out [*2];
  endproperty
  a_ignore_word: assert property (p_ignore_word)
    else $error("word taken during start-up");
  property p_tx_pause;
    clk_off_in && tx_busy_in |=> tx_pause_out;
  endproperty
  a_tx_pause: assert property (p_tx_pause)
    else $error("transmit not paused");
  property p_rx_pause;
    clk_off_in && rx_busy_in |=> rx_pause_out;
  endproperty
  a_rx_pause: assert property (p_rx_pause)
    else $error("receive not paused");
  property p_off_write;
    wr_in && addr_in == 2'h3 && clk_off_in |=> !tx_load_out;
  endproperty
  a_off_write: assert property (p_off_write)
    else $error("data write taken with clock off");
endmodule
bind uart_irq_wake uart_irq_wake_properties u_uart_irq_wake_properties (
  .clk_sys_in, .rst_in, .addr_in, .wr_in, .rx_word_valid_in, .rx_busy_in,
  .tx_busy_in, .rx_pin_in, .clk_off_in, .global_irq_enable_in,
  .stack_full_in, .tx_load_out, .irq_n_out, .vector_req_out, .wake_out,
  .rx_ignore_out, .tx_pause_out, .rx_pause_out);
